// >>> core/supply_monitor_pkg.sv
// Constants, register map and state layout of the supply monitor and interrupt block.
// Assumes one core clock and a register port that answers reads one cycle later.
package supply_monitor_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET   = 8'h04;
  localparam logic [7:0] OFS_IRQ_FLAGS        = 8'h08;
  localparam logic [7:0] OFS_POWER_CLOCK_STAT = 8'h0C;
  localparam logic [7:0] OFS_LOOP_CTRL        = 8'h24;
  localparam logic [7:0] OFS_LOOP_SYNC_CTRL   = 8'h30;
  localparam logic [7:0] OFS_MONITOR_CTRL     = 8'h34;
  localparam logic [7:0] OFS_REFERENCE_CTRL   = 8'h40;

  // ---------------------------------------------------------------------------
  // Status and interrupt bit positions
  // ---------------------------------------------------------------------------
  localparam int IRQ_N               = 12;
  localparam int EXT_N               = 9;
  localparam int BIT_LOOP_READY      = 4;
  localparam int BIT_MON_READY       = 9;
  localparam int BIT_LOW_DETECT      = 10;
  localparam int BIT_MON_SYNC_READY  = 11;

  // ---------------------------------------------------------------------------
  // Monitor control fields
  // ---------------------------------------------------------------------------
  localparam int MON_ENABLE_BIT      = 1;
  localparam int MON_THRESHOLD_MARGIN_ENABLE_BIT        = 2;
  localparam int MON_ACTION_LSB      = 3;
  localparam int MON_RUN_STANDBY_BIT = 6;
  localparam int MON_MODE_BIT        = 8;
  localparam int MON_CLK_EN_BIT      = 9;
  localparam int MON_PSEL_LSB        = 12;
  localparam int PSEL_W              = 4;
  localparam logic [15:0] MON_CTRL_MASK  = 16'hF35E;
  localparam logic [15:0] MON_CTRL_RESET = 16'h0000;
  localparam logic [1:0]  ACTION_NONE    = 2'h0;
  localparam logic [1:0]  ACTION_RESET   = 2'h1;
  localparam logic [1:0]  ACTION_IRQ     = 2'h2;

  // ---------------------------------------------------------------------------
  // Locked-loop and reference fields
  // ---------------------------------------------------------------------------
  localparam int LOOP_ENABLE_BIT       = 1;
  localparam logic [15:0] LOOP_CTRL_RESET = 16'h0080;
  localparam int REF_TEMP_SENSOR_ENABLE_BIT          = 1;
  localparam int REF_BGOUT_BIT         = 2;
  localparam int REF_TRIM_LSB          = 16;
  localparam int TRIM_W                = 11;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CORE_CLK_HZ         = 40_000_000;
  localparam int SAMPLE_ON_NS        = 2000;
  localparam int SAMPLE_ON_CYCLES    = (SAMPLE_ON_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [1:0] MON_SYNC_EDGES  = 2'h2;
  localparam logic [3:0] LOOP_SYNC_CYCLES = 4'h6;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
  } bus_req_s;

  typedef struct packed {
    logic              prev_presc;
    logic [16:0]       presc_cnt;
    logic [7:0]        on_cnt;
    logic              det;
    logic [IRQ_N-1:0]  stat_prev;
    logic [IRQ_N-1:0]  flags;
    logic [IRQ_N-1:0]  irq_en;
    logic [15:0]       mon_ctrl;
    logic [15:0]       mon_applied;
    logic [1:0]        mon_sync_cnt;
    logic [15:0]       loop_ctrl;
    logic [3:0]        loop_sync_cnt;
    logic              ref_temp_sensor_enable;
    logic              ref_bgout;
    logic [TRIM_W-1:0] trim;
    logic              trim_loaded;
    logic [31:0]       rdata;
    logic              stall;
  } state_s;

endpackage : supply_monitor_pkg

// >>> core/supply_monitor_irq_sync.sv
// Supply monitor, reference control, twelve-source interrupt bank and loop sync.
// Assumes the slow prescaler clock, status bits and comparator are synchronous inputs.
`timescale 1ns/100ps
module supply_monitor_irq_sync (
  // Clock and reset
  input  wire logic                                   core_clk_i,
  input  wire logic                                   rst_n_i,
  // Register port
  input  wire supply_monitor_pkg::bus_req_s           bus_req_i,
  output logic [31:0]                                 rdata_o,
  output logic                                        bus_stall_o,
  // Slow prescaler clock and analog comparator
  input  wire logic                                   prescaler_clk_i,
  input  wire logic                                   supply_low_cmp_i,
  // Oscillator and loop status, factory trim
  input  wire logic [supply_monitor_pkg::EXT_N-1:0]   osc_status_i,
  input  wire logic [supply_monitor_pkg::TRIM_W-1:0]  factory_trim_i,
  // Analog controls
  output logic                                        monitor_on_o,
  output logic                                        threshold_margin_o,
  output logic                                        temp_sensor_on_o,
  output logic                                        bandgap_route_o,
  output logic [supply_monitor_pkg::TRIM_W-1:0]       reference_trim_o,
  output logic [15:0]                                 loop_ctrl_o,
  // System side
  output logic                                        irq_o,
  output logic                                        supply_low_wake_o,
  output logic                                        supply_reset_o
);

  supply_monitor_pkg::state_s s_q;
  supply_monitor_pkg::state_s s_d;

  logic [supply_monitor_pkg::IRQ_N-1:0] status;
  logic                                 presc_edge;
  logic                                 mon_en;
  logic                                 sampling;
  logic                                 sample_tick;
  logic [16:0]                          sample_top;
  logic                                 mon_sync_ready;
  logic                                 loop_ready;
  logic [1:0]                           action;
  logic                                 hit_mon;
  logic                                 hit_loop;

  // ---------------------------------------------------------------------------
  // Status vector and sampling
  // ---------------------------------------------------------------------------
  assign presc_edge     = prescaler_clk_i && !s_q.prev_presc;
  assign mon_en         = s_q.mon_applied[supply_monitor_pkg::MON_ENABLE_BIT];
  assign sampling       = s_q.mon_applied[supply_monitor_pkg::MON_MODE_BIT];
  assign action         = s_q.mon_applied[supply_monitor_pkg::MON_ACTION_LSB +: 2];
  assign mon_sync_ready = (s_q.mon_sync_cnt == 2'h0);
  assign loop_ready     = osc_status_i[supply_monitor_pkg::BIT_LOOP_READY];
  assign hit_mon        = (bus_req_i.addr == supply_monitor_pkg::OFS_MONITOR_CTRL);
  assign hit_loop       = (bus_req_i.addr == supply_monitor_pkg::OFS_LOOP_CTRL);

  // The tick period is two to the power select plus one prescaler edges.
  assign sample_top = 17'((17'h1_0000 >> (4'hF -
                      s_q.mon_applied[supply_monitor_pkg::MON_PSEL_LSB +: supply_monitor_pkg::PSEL_W]))
                      - 17'h0_0001);
  assign sample_tick = presc_edge && (s_q.presc_cnt == sample_top);

  always_comb begin
    status = '0;
    status[supply_monitor_pkg::EXT_N-1:0]           = osc_status_i;
    status[supply_monitor_pkg::BIT_MON_READY]       = mon_en;
    status[supply_monitor_pkg::BIT_LOW_DETECT]      = s_q.det;
    status[supply_monitor_pkg::BIT_MON_SYNC_READY]  = mon_sync_ready;
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.prev_presc = prescaler_clk_i;
    s_d.stall      = 1'b0;
    s_d.stat_prev  = status;

    // Prescaler counter only runs with the monitor clock enabled in sampling mode.
    if (!sampling || !s_q.mon_applied[supply_monitor_pkg::MON_CLK_EN_BIT]) begin
      s_d.presc_cnt = 17'h0_0000;
    end else if (sample_tick) begin
      s_d.presc_cnt = 17'h0_0000;
    end else if (presc_edge) begin
      s_d.presc_cnt = s_q.presc_cnt + 17'h0_0001;
    end

    // Detection: continuous tracks the comparator, sampling latches at window end.
    if (!mon_en) begin
      s_d.on_cnt = 8'h00;
      s_d.det    = 1'b0;
    end else if (!sampling) begin
      s_d.on_cnt = 8'h00;
      s_d.det    = supply_low_cmp_i;
    end else begin
      if (sample_tick && s_q.mon_applied[supply_monitor_pkg::MON_CLK_EN_BIT]) begin
        s_d.on_cnt = 8'(supply_monitor_pkg::SAMPLE_ON_CYCLES);
      end else if (s_q.on_cnt != 8'h00) begin
        s_d.on_cnt = s_q.on_cnt - 8'h01;
      end
      if (s_q.on_cnt == 8'h01) begin
        s_d.det = supply_low_cmp_i;
      end
    end

    // Monitor write sync counts prescaler edges, then applies the new setting.
    if (!mon_sync_ready && presc_edge) begin
      s_d.mon_sync_cnt = s_q.mon_sync_cnt - 2'h1;
      if (s_q.mon_sync_cnt == 2'h1) begin
        s_d.mon_applied = s_q.mon_ctrl;
      end
    end

    if (s_q.loop_sync_cnt != 4'h0) begin
      s_d.loop_sync_cnt = s_q.loop_sync_cnt - 4'h1;
    end

    // Factory trim is caught in the first cycle after reset release.
    if (!s_q.trim_loaded) begin
      s_d.trim        = factory_trim_i;
      s_d.trim_loaded = 1'b1;
    end

    // Flags: a write of one clears, a new edge in the same cycle wins.
    if (bus_req_i.we && bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_FLAGS) begin
      s_d.flags = s_q.flags & ~bus_req_i.wdata[supply_monitor_pkg::IRQ_N-1:0];
    end
    s_d.flags = s_d.flags | (status & ~s_q.stat_prev);

    // Register writes.
    if (bus_req_i.we) begin
      if (bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR) begin
        s_d.irq_en = s_q.irq_en & ~bus_req_i.wdata[supply_monitor_pkg::IRQ_N-1:0];
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_ENABLE_SET) begin
        s_d.irq_en = s_q.irq_en | bus_req_i.wdata[supply_monitor_pkg::IRQ_N-1:0];
      end else if (hit_loop) begin
        if (loop_ready) begin
          s_d.loop_ctrl = bus_req_i.wdata[15:0];
        end
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_LOOP_SYNC_CTRL) begin
        if (bus_req_i.wdata[7]) begin
          s_d.loop_sync_cnt = supply_monitor_pkg::LOOP_SYNC_CYCLES;
        end
      end else if (hit_mon) begin
        if (mon_sync_ready) begin
          s_d.mon_ctrl     = bus_req_i.wdata[15:0] & supply_monitor_pkg::MON_CTRL_MASK;
          s_d.mon_sync_cnt = supply_monitor_pkg::MON_SYNC_EDGES;
        end else begin
          s_d.stall = 1'b1;
        end
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_REFERENCE_CTRL) begin
        s_d.ref_temp_sensor_enable  = bus_req_i.wdata[supply_monitor_pkg::REF_TEMP_SENSOR_ENABLE_BIT];
        s_d.ref_bgout = bus_req_i.wdata[supply_monitor_pkg::REF_BGOUT_BIT];
        s_d.trim      = bus_req_i.wdata[supply_monitor_pkg::REF_TRIM_LSB +:
                                        supply_monitor_pkg::TRIM_W];
      end
    end

    // Register reads, answered in the next cycle.
    s_d.rdata = 32'h0000_0000;
    if (bus_req_i.re) begin
      if (bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR ||
          bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_ENABLE_SET) begin
        s_d.rdata = 32'(s_q.irq_en);
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_IRQ_FLAGS) begin
        s_d.rdata = 32'(s_q.flags);
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_POWER_CLOCK_STAT) begin
        s_d.rdata = 32'(status);
      end else if (hit_loop) begin
        s_d.rdata = 32'(s_q.loop_ctrl);
        if (s_q.loop_ctrl[supply_monitor_pkg::LOOP_ENABLE_BIT] &&
            s_q.loop_sync_cnt == 4'h0) begin
          s_d.stall         = 1'b1;
          s_d.loop_sync_cnt = supply_monitor_pkg::LOOP_SYNC_CYCLES;
        end
      end else if (hit_mon) begin
        s_d.rdata = 32'(s_q.mon_ctrl);
        if (!mon_sync_ready) begin
          s_d.stall = 1'b1;
        end
      end else if (bus_req_i.addr == supply_monitor_pkg::OFS_REFERENCE_CTRL) begin
        s_d.rdata[supply_monitor_pkg::REF_TEMP_SENSOR_ENABLE_BIT]  = s_q.ref_temp_sensor_enable;
        s_d.rdata[supply_monitor_pkg::REF_BGOUT_BIT] = s_q.ref_bgout;
        s_d.rdata[supply_monitor_pkg::REF_TRIM_LSB +: supply_monitor_pkg::TRIM_W] = s_q.trim;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.mon_ctrl <= supply_monitor_pkg::MON_CTRL_RESET;
      s_q.mon_applied <= supply_monitor_pkg::MON_CTRL_RESET;
      s_q.loop_ctrl   <= supply_monitor_pkg::LOOP_CTRL_RESET;
      // Sync ready idles high, so a zero history would raise a false flag after reset.
      s_q.stat_prev[supply_monitor_pkg::BIT_MON_SYNC_READY] <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rdata_o            = s_q.rdata;
  assign bus_stall_o        = s_q.stall;
  assign monitor_on_o       = mon_en && (!sampling || s_q.on_cnt != 8'h00);
  assign threshold_margin_o = s_q.mon_applied[supply_monitor_pkg::MON_THRESHOLD_MARGIN_ENABLE_BIT];
  assign temp_sensor_on_o   = s_q.ref_temp_sensor_enable;
  assign bandgap_route_o    = s_q.ref_bgout;
  assign reference_trim_o   = s_q.trim;
  assign loop_ctrl_o        = s_q.loop_ctrl;
  assign irq_o              = |(s_q.flags & s_q.irq_en);
  assign supply_reset_o     = s_q.det && (action == supply_monitor_pkg::ACTION_RESET);

  // The wake path bypasses the clock so it still works with the core clock stopped.
  assign supply_low_wake_o  = supply_low_cmp_i && mon_en &&
                              (action == supply_monitor_pkg::ACTION_IRQ) &&
                              s_q.irq_en[supply_monitor_pkg::BIT_LOW_DETECT];

endmodule : supply_monitor_irq_sync

// >>> test/supply_monitor_checker.sv
// Concurrent checks on the supply monitor block, bound to its top-level ports.
// Assumes one core clock with a synchronous active-low reset.
`timescale 1ns/100ps
module supply_monitor_checker (
  input wire logic                         core_clk_i,
  input wire logic                         rst_n_i,
  input wire supply_monitor_pkg::bus_req_s bus_req_i,
  input wire logic [31:0]                  rdata_o,
  input wire logic                         bus_stall_o,
  input wire logic                         prescaler_clk_i,
  input wire logic                         supply_low_cmp_i,
  input wire logic [8:0]                   osc_status_i,
  input wire logic [10:0]                  factory_trim_i,
  input wire logic                         temp_sensor_on_o,
  input wire logic                         bandgap_route_o,
  input wire logic [10:0]                  reference_trim_o,
  input wire logic [15:0]                  loop_ctrl_o,
  input wire logic                         irq_o,
  input wire logic                         supply_low_wake_o
);
  logic [31:0] wdata_q;
  wire logic [7:0] a = bus_req_i.addr;

  always_ff @(posedge core_clk_i) begin
    wdata_q <= bus_req_i.wdata;
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // A second prescaler edge is needed to finish a sync, so one cycle can never end it.
  sequence mon_wr;
    bus_req_i.we && a == supply_monitor_pkg::OFS_MONITOR_CTRL;
  endsequence
  sequence mon_taken;
    mon_wr ##1 !bus_stall_o && !$rose(prescaler_clk_i);
  endsequence

  sync_busy_stall_a: assert property (mon_taken ##0 mon_wr |=> bus_stall_o)
    else $error("monitor write during sync not stalled");
  sync_ready_clear_a: assert property (
    mon_taken ##1 (bus_req_i.re && a == supply_monitor_pkg::OFS_POWER_CLOCK_STAT
    && !$rose(prescaler_clk_i)) |=> !rdata_o[11]) else $error("sync ready not cleared");
  loop_idle_read_a: assert property (
    bus_req_i.re && a == supply_monitor_pkg::OFS_LOOP_CTRL && !loop_ctrl_o[1] |=> !bus_stall_o)
    else $error("loop read stalled while loop disabled");
  loop_write_drop_a: assert property (
    bus_req_i.we && a == supply_monitor_pkg::OFS_LOOP_CTRL && !osc_status_i[4]
    |=> $stable(loop_ctrl_o)) else $error("loop write taken while not ready");
  ref_enables_a: assert property (
    bus_req_i.we && a == supply_monitor_pkg::OFS_REFERENCE_CTRL
    |=> temp_sensor_on_o == wdata_q[1] && bandgap_route_o == wdata_q[2])
    else $error("reference enables do not follow write");
  trim_factory_a: assert property (
    $rose(rst_n_i) |=> reference_trim_o == $past(factory_trim_i))
    else $error("trim not loaded from factory value");
  wake_cause_a: assert property (supply_low_wake_o |-> supply_low_cmp_i)
    else $error("wake without low supply");
  enable_clear_a: assert property (
    bus_req_i.we && a == supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR
    && bus_req_i.wdata[11:0] == 12'hFFF |=> !irq_o) else $error("irq after clearing enables");
endmodule : supply_monitor_checker

bind supply_monitor_irq_sync supply_monitor_checker chk (.*);

// >>> test/supply_monitor_irq_sync_bench.sv
// Self-checking bench for the supply monitor block: random and corner stimulus.
// Assumes the package, the design and its bound checker are compiled first.
`timescale 1ns/100ps
module supply_monitor_irq_sync_bench;
  logic                         core_clk_i = 1'b0;
  logic                         rst_n_i = 1'b0;
  supply_monitor_pkg::bus_req_s bus_req_i = '0;
  logic                         prescaler_clk_i = 1'b0;
  logic                         supply_low_cmp_i = 1'b0;
  logic [8:0]                   osc_status_i = '0;
  logic [10:0]                  factory_trim_i = '0;
  logic [31:0]                  rdata_o, rv, d;
  logic [15:0]                  loop_ctrl_o;
  logic [10:0]                  reference_trim_o;
  logic                         bus_stall_o, monitor_on_o, threshold_margin_o;
  logic                         temp_sensor_on_o, bandgap_route_o, irq_o;
  logic                         supply_low_wake_o, supply_reset_o;
  logic                         meas = 1'b0;
  logic                         on_q = 1'b0;
  integer                       seed = 32'hac81;
  int                           n_errors = 0;
  int                           compares = 0;
  int                           stalls = 0;
  int                           ons = 0;
  int                           rises = 0;
  int                           s0, sel;

  supply_monitor_irq_sync dut (.*);

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Stall pulses last one cycle, so they are counted here rather than polled.
  always @(posedge core_clk_i) begin
    on_q <= monitor_on_o;
    stalls <= stalls + int'(bus_stall_o);
    ons <= meas ? ons + int'(monitor_on_o) : 0;
    rises <= meas ? rises + int'(monitor_on_o && !on_q) : 0;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic put(input logic [7:0] a, input logic [31:0] wd, input logic w);
    @(posedge core_clk_i);
    bus_req_i <= '{a, wd, w, !w};
  endtask : put

  task automatic acc(input logic [7:0] a, input logic [31:0] wd, input logic w);
    put(a, wd, w);
    @(posedge core_clk_i);
    bus_req_i <= '0;
    #1;
    rv = rdata_o;
  endtask : acc

  // Each prescaler period is 200 core cycles, longer than one sampling burst.
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge core_clk_i);
      prescaler_clk_i <= 1'b1;
      repeat (100) @(posedge core_clk_i);
      prescaler_clk_i <= 1'b0;
      repeat (99) @(posedge core_clk_i);
    end
  endtask : edges

  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    factory_trim_i <= 11'($random(seed));
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    acc(supply_monitor_pkg::OFS_MONITOR_CTRL, '0, 1'b0);
    chk("monitor control", 32'h0, rv);
    chk("trim", factory_trim_i, reference_trim_o);
    acc(supply_monitor_pkg::OFS_POWER_CLOCK_STAT, '0, 1'b0);
    chk("status", 32'h0000_0800, rv);
    acc(supply_monitor_pkg::OFS_IRQ_FLAGS, '0, 1'b0);
    chk("flags after reset", 32'h0, rv);
    repeat (4) begin
      d = $random(seed);
      acc(supply_monitor_pkg::OFS_REFERENCE_CTRL, d, 1'b1);
      chk("temp sensor", d[1], temp_sensor_on_o);
      chk("bandgap route", d[2], bandgap_route_o);
      chk("trim", d[26:16], reference_trim_o);
      acc(supply_monitor_pkg::OFS_REFERENCE_CTRL, '0, 1'b0);
      chk("reference", d & 32'h07FF_0006, rv);
    end
    acc(supply_monitor_pkg::OFS_IRQ_FLAGS, 32'h0000_0FFF, 1'b1);
    for (int k = 0; k < 9; k++) begin
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_SET, 1 << k, 1'b1);
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR, '0, 1'b1);
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR, '0, 1'b0);
      chk("enables", 1 << k, rv);
      @(posedge core_clk_i);
      osc_status_i <= 9'((1 << k) | (1 << ((k + 3) % 9)));
      repeat (3) @(posedge core_clk_i);
      acc(supply_monitor_pkg::OFS_IRQ_FLAGS, '0, 1'b0);
      chk("flags", (1 << k) | (1 << ((k + 3) % 9)), rv);
      chk("irq raised", 1, irq_o);
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR, 1 << k, 1'b1);
      chk("irq disabled", 0, irq_o);
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_SET, 1 << k, 1'b1);
      chk("irq enabled", 1, irq_o);
      acc(supply_monitor_pkg::OFS_IRQ_FLAGS, 1 << k, 1'b1);
      chk("irq cleared", 0, irq_o);
      @(posedge core_clk_i);
      osc_status_i <= '0;
      acc(supply_monitor_pkg::OFS_IRQ_FLAGS, 32'h0000_0FFF, 1'b1);
      acc(supply_monitor_pkg::OFS_IRQ_ENABLE_CLEAR, 32'h0000_0FFF, 1'b1);
    end
    s0 = stalls;
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, 32'h0000_00FF, 1'b1);
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, '0, 1'b0);
    chk("loop dropped", 32'h0000_0080, rv);
    @(posedge core_clk_i);
    osc_status_i[4] <= 1'b1;
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, 32'h0000_0002, 1'b1);
    chk("loop control", 32'h0000_0002, loop_ctrl_o);
    chk("idle loop stalls", s0, stalls);
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, '0, 1'b0);
    chk("loop read", 32'h0000_0002, rv);
    acc(supply_monitor_pkg::OFS_LOOP_SYNC_CTRL, 32'h0000_0080, 1'b1);
    chk("loop stalls", s0 + 1, stalls);
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, '0, 1'b0);
    acc(supply_monitor_pkg::OFS_LOOP_CTRL, '0, 1'b1);
    chk("requested read stalls", s0 + 1, stalls);
    put(supply_monitor_pkg::OFS_MONITOR_CTRL, 32'h0000_0006, 1'b1);
    put(supply_monitor_pkg::OFS_MONITOR_CTRL, 32'h0000_0000, 1'b1);
    acc(supply_monitor_pkg::OFS_POWER_CLOCK_STAT, '0, 1'b0);
    chk("sync busy", 32'h0, rv[11]);
    chk("busy write stalls", s0 + 2, stalls);
    // Two reads of the written register while busy; only the first pulse is counted yet.
    put(supply_monitor_pkg::OFS_MONITOR_CTRL, '0, 1'b0);
    acc(supply_monitor_pkg::OFS_MONITOR_CTRL, '0, 1'b0);
    chk("busy read stalls", s0 + 3, stalls);
    edges(2);
    acc(supply_monitor_pkg::OFS_POWER_CLOCK_STAT, '0, 1'b0);
    chk("status", 32'h0000_0A10, rv);
    chk("margin", 1, threshold_margin_o);
    chk("continuous on", 1, monitor_on_o);
    acc(supply_monitor_pkg::OFS_MONITOR_CTRL, '0, 1'b0);
    chk("monitor control", 32'h0000_0006, rv);
    acc(supply_monitor_pkg::OFS_IRQ_ENABLE_SET, 32'h0000_0400, 1'b1);
    for (int act = 1; act < 3; act++) begin
      acc(supply_monitor_pkg::OFS_MONITOR_CTRL, 32'h2 | (act << 3), 1'b1);
      edges(2);
      supply_low_cmp_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      #1;
      chk("margin off", 0, threshold_margin_o);
      chk("reset action", act == 1, supply_reset_o);
      chk("wake", act == 2, supply_low_wake_o);
      @(posedge core_clk_i);
      supply_low_cmp_i <= 1'b0;
    end
    sel = {$random(seed)} % 3;
    acc(supply_monitor_pkg::OFS_MONITOR_CTRL, 32'h0102 | (sel << 12), 1'b1);
    edges(2);
    acc(supply_monitor_pkg::OFS_MONITOR_CTRL, 32'h0302 | (sel << 12), 1'b1);
    edges(2);
    meas <= 1'b1;
    edges(2 << (sel + 1));
    meas <= 1'b0;
    #1;
    chk("ticks", 2, rises);
    chk("on cycles", 2 * supply_monitor_pkg::SAMPLE_ON_CYCLES, ons);
    results();
  end
endmodule : supply_monitor_irq_sync_bench
